//--- logic/tsc_pkg.sv
// Shared constants and types of the store command handler.
// Assumes one 10 MHz clock and byte-wide framed command traffic.
package tsc_pkg;
  localparam logic [7:0] HDR_BYTE        = 8'h55;
  localparam logic [7:0] CMD_STORE_READ  = 8'h28;
  localparam logic [7:0] CMD_STORE_WRITE = 8'h29;
  localparam logic [7:0] CMD_RELOAD      = 8'h2b;
  localparam logic [7:0] CMD_TOUCH_OFF   = 8'h13;
  localparam logic [7:0] CMD_CALIBRATE   = 8'h14;
  localparam logic [7:0] RSP_OK          = 8'h00;
  localparam logic [7:0] RSP_BAD_COUNT   = 8'h03;
  localparam logic [7:0] RSP_BAD_CMD     = 8'h01;
  localparam logic [7:0] LEN_RW_BASE     = 8'h04;
  localparam logic [7:0] LEN_ANS_BASE    = 8'h02;
  localparam logic [7:0] CNT_MIN         = 8'h01;
  localparam logic [7:0] CNT_MAX         = 8'h08;
  localparam int         STORE_DEPTH     = 256;
  localparam logic [7:0] USER_BASE       = 8'h80;
  // Plain layout: settings at 0x03, calibration block from 0x14 to 0x25
  localparam logic [7:0] CFG_BASE_PLAIN  = 8'h03;
  localparam logic [7:0] CFG_BASE_CSUM   = 8'h04;
  localparam logic [7:0] CFG_KEY_ADDR    = 8'h01;
  localparam logic [7:0] CFG_CSUM_ADDR   = 8'h15;
  localparam logic [7:0] CAL_KEY_PLAIN   = 8'h14;
  localparam logic [7:0] CAL_KEY_CSUM    = 8'h16;
  localparam logic [7:0] CAL_CSUM_ADDR   = 8'h28;
  localparam logic [7:0] CTRL_END        = 8'h7f;
  localparam int         CFG_COUNT       = 16;
  localparam int         CAL_COUNT       = 18;
  localparam logic [7:0] CFG_OPT_INDEX   = 8'h0b;
  localparam logic [7:0] CCE_MASK        = 8'h01;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } tsc_byte_t;

  typedef enum logic [1:0] {
    TSC_ACC_IDLE,
    TSC_ACC_READ,
    TSC_ACC_WRITE
  } tsc_acc_t;
endpackage

//--- logic/tsc_store.sv
// 256-byte nonvolatile store model with one read and one write port.
// Assumes the caller never writes and reads the same address in one cycle.
`timescale 1ns/1ns
module tsc_store #(
  parameter int DEPTH = 256
) (
  input  wire logic       clk_i,
  input  wire logic       we_i,
  input  wire logic [7:0] waddr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [7:0] raddr_i,
  output logic      [7:0] rdata_o
);
  import tsc_pkg::*;
  logic [7:0] mem [DEPTH];

  // Store holds its contents across reset, as a nonvolatile part would
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_o <= mem[raddr_i];
  end
endmodule

//--- logic/tsc_tx.sv
// Answer sender: registers each pushed byte out onto the link, one per cycle.
// Assumes the link accepts a byte on every valid cycle.
`timescale 1ns/1ns
module tsc_tx (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             push_i,
  input  wire logic       [7:0] byte_i,
  output tsc_pkg::tsc_byte_t    out_o
);
  import tsc_pkg::*;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_o <= '0;
    end else begin
      out_o.valid <= push_i;
      out_o.data  <= push_i ? byte_i : 8'h00;
    end
  end
endmodule

//--- logic/tsc_store_cmd.sv
// Command framer for the store commands. Bytes arrive on RX_I, answers leave
// on TX_O. Live configuration and calibration appear as plain ports.
`timescale 1ns/1ns
module tsc_store_cmd #(
  parameter bit CSUM_LAYOUT = 1'b0
) (
  input  wire logic                   CLK_I,
  input  wire logic                   RST_I,
  input  wire tsc_pkg::tsc_byte_t     RX_I,
  output tsc_pkg::tsc_byte_t          TX_O,
  input  wire logic                   CAL_ACTIVE_I,
  input  wire logic                   CAL_DONE_I,
  input  wire logic [8*tsc_pkg::CAL_COUNT-1:0] CAL_DATA_I,
  output logic                        CAL_ABORT_O,
  output logic                        TOUCH_EN_O,
  output logic                        CFG_BUSY_O,
  output logic [8*tsc_pkg::CFG_COUNT-1:0] CFG_O,
  output logic                        CAL_OUT_EN_O
);
  import tsc_pkg::*;

  typedef enum logic [3:0] {
    S_HDR, S_LEN, S_CMD, S_AHI, S_ALO, S_CNT, S_DATA,
    S_LOAD, S_CALSAVE, S_RDATA, S_ANS, S_SKIP
  } tsc_state_t;

  localparam logic [7:0] CFG_BASE = CSUM_LAYOUT ? CFG_BASE_CSUM : CFG_BASE_PLAIN;
  localparam logic [7:0] CAL_BASE = CSUM_LAYOUT ? CAL_KEY_CSUM : CAL_KEY_PLAIN;

  tsc_state_t state;
  logic [7:0] len, cmd, addr, cnt, idx, code, skip;
  logic       we, push;
  logic [7:0] waddr, wdata, raddr, rdata, tx_byte;
  logic [2:0] hdr_pos;
  logic       rd_pend;

  // Lower address only; the high byte is parsed and dropped
  tsc_store #(.DEPTH(STORE_DEPTH)) u_store (
    .clk_i   (CLK_I),
    .we_i    (we),
    .waddr_i (waddr),
    .wdata_i (wdata),
    .raddr_i (raddr),
    .rdata_o (rdata)
  );

  tsc_tx u_tx (
    .clk_i  (CLK_I),
    .rst_i  (RST_I),
    .push_i (push),
    .byte_i (tx_byte),
    .out_o  (TX_O)
  );

  function automatic logic cnt_ok(input logic [7:0] c);
    return c >= CNT_MIN && c <= CNT_MAX;
  endfunction

  // Frame parser and sequencer
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state   <= S_LOAD;
      len     <= 8'h00;
      // No command pending, so the power-up load ends without an answer
      cmd     <= 8'h00;
      addr    <= 8'h00;
      cnt     <= 8'h00;
      idx     <= 8'h00;
      code    <= RSP_OK;
      skip    <= 8'h00;
      hdr_pos <= 3'h0;
      rd_pend <= 1'b0;
    end else begin
      unique case (state)
        S_HDR: begin
          if (RX_I.valid && RX_I.data == HDR_BYTE) begin
            state <= S_LEN;
          end
        end
        S_LEN: begin
          if (RX_I.valid) begin
            len   <= RX_I.data;
            state <= S_CMD;
          end
        end
        S_CMD: begin
          if (RX_I.valid) begin
            cmd  <= RX_I.data;
            code <= RSP_OK;
            unique case (RX_I.data)
              CMD_STORE_READ, CMD_STORE_WRITE: state <= S_AHI;
              CMD_RELOAD: begin
                idx   <= 8'h00;
                state <= S_LOAD;
              end
              CMD_TOUCH_OFF: state <= S_ANS;
              default: begin
                code  <= RSP_BAD_CMD;
                skip  <= len - 8'h01;
                state <= (len > 8'h01) ? S_SKIP : S_ANS;
              end
            endcase
          end
        end
        S_AHI: if (RX_I.valid) state <= S_ALO;
        S_ALO: begin
          if (RX_I.valid) begin
            addr  <= RX_I.data;
            state <= S_CNT;
          end
        end
        S_CNT: begin
          if (RX_I.valid) begin
            cnt <= RX_I.data;
            idx <= 8'h00;
            if (!cnt_ok(RX_I.data)) begin
              code  <= RSP_BAD_COUNT;
              skip  <= (cmd == CMD_STORE_WRITE) ? len - LEN_RW_BASE : 8'h00;
              state <= (cmd == CMD_STORE_WRITE && len > LEN_RW_BASE) ? S_SKIP : S_ANS;
            end else if (cmd == CMD_STORE_WRITE) begin
              state <= S_DATA;
            end else begin
              state <= S_ANS;
            end
          end
        end
        S_DATA: begin
          if (RX_I.valid) begin
            idx <= idx + 8'h01;
            if (idx + 8'h01 == cnt) begin
              state <= S_ANS;
            end
          end
        end
        S_SKIP: begin
          if (RX_I.valid) begin
            skip <= skip - 8'h01;
            if (skip == 8'h01) begin
              state <= S_ANS;
            end
          end
        end
        S_LOAD: begin
          // Store read latency is one cycle; rd_pend marks a byte in flight
          rd_pend <= idx < CFG_COUNT[7:0];
          if (rd_pend) begin
            if (idx == CFG_COUNT[7:0]) begin
              idx     <= 8'h00;
              rd_pend <= 1'b0;
              state   <= (cmd == CMD_RELOAD) ? S_ANS : S_HDR;
            end
          end
          if (idx < CFG_COUNT[7:0]) begin
            idx <= idx + 8'h01;
          end
        end
        S_CALSAVE: begin
          idx <= idx + 8'h01;
          if (idx == CAL_COUNT[7:0] - 8'h01) begin
            idx   <= 8'h00;
            state <= S_HDR;
          end
        end
        S_ANS: begin
          hdr_pos <= hdr_pos + 3'h1;
          if (hdr_pos == 3'h3) begin
            hdr_pos <= 3'h0;
            idx     <= 8'h00;
            state   <= (cmd == CMD_STORE_READ && code == RSP_OK) ? S_RDATA : S_HDR;
          end
        end
        S_RDATA: begin
          idx <= idx + 8'h01;
          if (idx == cnt) begin
            state <= S_HDR;
          end
        end
        default: state <= S_HDR;
      endcase
      if (state == S_HDR && CAL_DONE_I && !RX_I.valid) begin
        idx   <= 8'h00;
        state <= S_CALSAVE;
      end
    end
  end

  // Store port steering; config index shifted by one to allow for read latency
  logic [7:0] load_slot;
  assign load_slot = idx - 8'h01;
  always_comb begin
    we    = 1'b0;
    waddr = 8'h00;
    wdata = 8'h00;
    raddr = 8'h00;
    if (state == S_DATA && RX_I.valid) begin
      we    = 1'b1;
      waddr = addr + idx;
      wdata = RX_I.data;
    end else if (state == S_CALSAVE) begin
      we    = 1'b1;
      waddr = CAL_BASE + idx;
      wdata = CAL_DATA_I[8*(CAL_COUNT-1-idx[4:0]) +: 8];
    end
    if (state == S_LOAD) begin
      raddr = CFG_BASE + idx;
    end else if (state == S_ANS || state == S_RDATA) begin
      raddr = addr + idx;
    end
  end

  // Live configuration is refreshed only by the load sequence
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CFG_O <= '0;
    end else if (state == S_LOAD && rd_pend) begin
      CFG_O[8*(CFG_COUNT-1-load_slot[3:0]) +: 8] <= rdata;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CAL_OUT_EN_O <= 1'b0;
    end else if (state == S_CALSAVE && idx == CAL_COUNT[7:0] - 8'h01) begin
      CAL_OUT_EN_O <= 1'b1;
    end else if (state == S_LOAD && rd_pend && load_slot == CFG_OPT_INDEX) begin
      CAL_OUT_EN_O <= |(rdata & CCE_MASK);
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      TOUCH_EN_O <= 1'b1;
    end else if (state == S_CMD && RX_I.valid && RX_I.data == CMD_TOUCH_OFF) begin
      TOUCH_EN_O <= 1'b0;
    end
  end

  // Calibration abort: first byte of any frame cancels it
  assign CAL_ABORT_O = CAL_ACTIVE_I && state == S_HDR && RX_I.valid
                       && RX_I.data == HDR_BYTE;
  assign CFG_BUSY_O  = state == S_LOAD;

  // Answer bytes: header, length, code, command, then read data
  always_comb begin
    push    = 1'b0;
    tx_byte = 8'h00;
    if (state == S_ANS) begin
      push = 1'b1;
      unique case (hdr_pos)
        3'h0: tx_byte = HDR_BYTE;
        3'h1: tx_byte = (cmd == CMD_STORE_READ && code == RSP_OK) ? LEN_ANS_BASE + cnt
                                                                  : LEN_ANS_BASE;
        3'h2: tx_byte = code;
        default: tx_byte = cmd;
      endcase
    end else if (state == S_RDATA && idx != 8'h00) begin
      push    = 1'b1;
      tx_byte = rdata;
    end
  end

  a_bad_count_no_write: assert property (@(posedge CLK_I) disable iff (RST_I)
    state == S_CNT && RX_I.valid && !cnt_ok(RX_I.data) |=> !we [*2])
    else $error("write after bad count");
  a_read_len: assert property (@(posedge CLK_I) disable iff (RST_I)
    state == S_ANS && hdr_pos == 3'h1 && cmd == CMD_STORE_READ && code == RSP_OK
    |-> tx_byte == cnt + 8'h02)
    else $error("read answer length wrong");
  a_touch_off: assert property (@(posedge CLK_I) disable iff (RST_I)
    state == S_CMD && RX_I.valid && RX_I.data == CMD_TOUCH_OFF |=> !TOUCH_EN_O ##3 TX_O.valid)
    else $error("touch disable not answered");
  a_abort_cal: assert property (@(posedge CLK_I) disable iff (RST_I)
    CAL_ACTIVE_I && state == S_HDR && RX_I.valid && RX_I.data == HDR_BYTE
    |-> CAL_ABORT_O ##1 state == S_LEN)
    else $error("calibration not abandoned");
  a_cal_enable: assert property (@(posedge CLK_I) disable iff (RST_I)
    state == S_CALSAVE && idx == CAL_COUNT[7:0] - 8'h01 |=> CAL_OUT_EN_O && state == S_HDR)
    else $error("calibration not enabled");
  a_cfg_stable: assert property (@(posedge CLK_I) disable iff (RST_I)
    state != S_LOAD |=> $stable(CFG_O))
    else $error("config changed outside load");
  a_write_count: assert property (@(posedge CLK_I) disable iff (RST_I)
    we && state == S_DATA |-> idx < CNT_MAX)
    else $error("too many bytes written");
  a_reload_answer: assert property (@(posedge CLK_I) disable iff (RST_I)
    state == S_LOAD && cmd == CMD_RELOAD && rd_pend && idx == CFG_COUNT[7:0]
    |=> state == S_ANS ##1 TX_O.valid && TX_O.data == HDR_BYTE)
    else $error("reload answer missing");
  c_read: cover property (@(posedge CLK_I) state == S_RDATA && idx == cnt);
  c_write: cover property (@(posedge CLK_I) state == S_DATA && we);
  c_bad: cover property (@(posedge CLK_I) code == RSP_BAD_COUNT && state == S_ANS);
endmodule

//--- testbench/tsc_host.sv
// Host model that frames store commands onto the handler's byte input.
// Assumes the caller waits for each answer before it sends the next frame.
`timescale 1ns/1ns
module tsc_host (
  input  wire logic          clk_i,
  output tsc_pkg::tsc_byte_t rx_o
);
  import tsc_pkg::*;
  initial rx_o = '{valid: 1'b0, data: 8'h00};
  // Idle data is inverted so a stale byte never looks like a fresh one
  task automatic send(input logic [7:0] fr[$]);
    foreach (fr[i]) begin
      @(negedge clk_i);
      rx_o <= '{valid: 1'b1, data: fr[i]};
    end
    @(negedge clk_i);
    rx_o <= '{valid: 1'b0, data: ~fr[fr.size()-1]};
  endtask
  task automatic send_read(input logic [7:0] hi, input logic [7:0] a, input logic [7:0] n);
    send({HDR_BYTE, LEN_RW_BASE, CMD_STORE_READ, hi, a, n});
  endtask
  task automatic send_write(input logic [7:0] a, input logic [7:0] d[$]);
    send({HDR_BYTE, 8'(LEN_RW_BASE + d.size()), CMD_STORE_WRITE,
          8'h00, a, 8'(d.size()), d});
  endtask
  task automatic send_short(input logic [7:0] cmd);
    send({HDR_BYTE, 8'h01, cmd});
  endtask
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the store command handler.
// Assumes the plain layout and a store that holds only what the bench wrote.
`timescale 1ns/1ns
module tb_top;
  import tsc_pkg::*;
  logic         clk;
  logic         rst;
  tsc_byte_t    rx;
  tsc_byte_t    tx;
  logic         cal_act;
  logic         cal_done;
  logic [8*CAL_COUNT-1:0] cal_data;
  logic         cal_abort;
  logic         touch_en;
  logic         cfg_busy;
  logic [127:0] cfg;
  logic         cal_en;
  logic [7:0]   mem [256];
  logic [7:0]   expq [$];
  logic [31:0]  lfsr_st = 32'h12016ef1;
  int           n_errors = 0;
  int           num_checks = 0;
  int           aborts = 0;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  tsc_host host (.clk_i(clk), .rx_o(rx));
  tsc_store_cmd DUT (.CLK_I(clk), .RST_I(rst), .RX_I(rx), .TX_O(tx),
    .CAL_ACTIVE_I(cal_act), .CAL_DONE_I(cal_done), .CAL_DATA_I(cal_data),
    .CAL_ABORT_O(cal_abort), .TOUCH_EN_O(touch_en), .CFG_BUSY_O(cfg_busy),
    .CFG_O(cfg), .CAL_OUT_EN_O(cal_en));

  function automatic logic [7:0] rnd();
    lfsr_st = {lfsr_st[30:0], ^(lfsr_st & 32'h80200003)};
    return lfsr_st[7:0];
  endfunction

  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Oldest note is matched against each answer byte as it leaves
  always @(posedge clk) begin
    if (cal_abort === 1'b1) aborts++;
    if (tx.valid === 1'b1) begin
      if (expq.size() == 0) chk("unexpected answer byte", 128'h0, 128'h1);
      else chk("answer byte", expq.pop_front(), tx.data);
    end
  end

  // No new frame until the answer is out and no load is running
  task automatic settle();
    int k;
    k = 0;
    while ((expq.size() != 0 || cfg_busy !== 1'b0) && k < 400) begin
      @(negedge clk);
      k++;
    end
    if (k >= 400) chk("answer wait", 128'h0, 128'h1);
    repeat (2) @(negedge clk);
  endtask

  task automatic ans(input logic [7:0] len, input logic [7:0] code, input logic [7:0] cmd);
    expq.push_back(HDR_BYTE);
    expq.push_back(len);
    expq.push_back(code);
    expq.push_back(cmd);
  endtask

  task automatic rd(input logic [7:0] hi, input logic [7:0] a, input logic [7:0] n);
    bit ok;
    ok = n >= CNT_MIN && n <= CNT_MAX;
    ans(ok ? 8'(LEN_ANS_BASE + n) : LEN_ANS_BASE, ok ? RSP_OK : RSP_BAD_COUNT, CMD_STORE_READ);
    for (int i = 0; ok && i < n; i++) expq.push_back(mem[8'(a + i)]);
    host.send_read(hi, a, n);
    settle();
  endtask

  task automatic wr(input logic [7:0] a, input int n, input logic [7:0] keep = 8'hff);
    logic [7:0] d[$];
    bit         ok;
    ok = n >= 1 && n <= 8;
    for (int i = 0; i < n; i++) d.push_back(rnd() & keep);
    if (ok) foreach (d[i]) mem[8'(a + i)] = d[i];
    ans(LEN_ANS_BASE, ok ? RSP_OK : RSP_BAD_COUNT, CMD_STORE_WRITE);
    host.send_write(a, d);
    settle();
  endtask

  task automatic sc(input logic [7:0] cmd, input logic [7:0] code = RSP_OK);
    ans(LEN_ANS_BASE, code, cmd);
    host.send_short(cmd);
    settle();
  endtask

  initial begin
    #(100 * 30000);
    n_errors++;
    final_report();
  end

  initial begin
    logic [7:0] old0;
    int         k;
    rst = 1'b1;
    cal_act = 1'b0;
    cal_done = 1'b0;
    cal_data = '0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    chk("load busy after reset", 1'b1, cfg_busy);
    settle();
    chk("touch enable after reset", 1'b1, touch_en);
    wr(8'h80, 8);
    wr(8'hff, 1);
    wr(8'h80, 9);
    rd(8'h5a, 8'h80, 8);
    rd(8'h00, 8'hff, 1);
    rd(8'h00, 8'h80, 0);
    rd(8'h00, 8'h80, 9);
    sc(8'h30, RSP_BAD_CMD);
    ans(LEN_ANS_BASE, RSP_BAD_CMD, 8'h31);
    host.send({HDR_BYTE, 8'h03, 8'h31, 8'h11, 8'h22});
    settle();
    $display("test store_rw done");
    // Lower-half writes stand in for a factory preload of the settings
    wr(CFG_BASE_PLAIN, 8);
    wr(CFG_BASE_PLAIN + 8'h08, 8);
    wr(CFG_BASE_PLAIN + CFG_OPT_INDEX, 1, ~CCE_MASK);
    sc(CMD_RELOAD);
    chk("calibrated output after reload", 1'b0, cal_en);
    old0 = mem[CFG_BASE_PLAIN];
    wr(CFG_BASE_PLAIN, 1);
    chk("setting 0 before reload", old0, cfg[127:120]);
    sc(CMD_RELOAD);
    chk("setting 0", mem[CFG_BASE_PLAIN], cfg[127:120]);
    chk("setting 15", mem[8'h12], cfg[7:0]);
    for (int i = 1; i < CFG_COUNT; i++) begin
      chk("setting", mem[CFG_BASE_PLAIN + 8'(i)], cfg[127 - 8 * i -: 8]);
    end
    $display("test reload done");
    cal_act = 1'b1;
    k = aborts;
    sc(CMD_TOUCH_OFF);
    chk("calibration abort pulses", k + 1, aborts);
    chk("touch enable", 1'b0, touch_en);
    cal_act = 1'b0;
    $display("test touch_off done");
    for (int i = 0; i < CAL_COUNT; i++) begin
      cal_data[8 * CAL_COUNT - 1 - 8 * i -: 8] = rnd();
      mem[8'(CAL_KEY_PLAIN + i)] = cal_data[8 * CAL_COUNT - 1 - 8 * i -: 8];
    end
    cal_done = 1'b1;
    @(negedge clk);
    cal_done = 1'b0;
    k = 0;
    while (cal_en !== 1'b1 && k < 300) begin
      @(negedge clk);
      k++;
    end
    chk("calibrated output enable", 1'b1, cal_en);
    settle();
    rd(8'h00, CAL_KEY_PLAIN, 8);
    rd(8'h00, 8'h1c, 8);
    rd(8'h00, 8'h24, 2);
    $display("test cal_save done");
    wr(CFG_BASE_PLAIN, 1);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    settle();
    chk("setting 0 after power-up", mem[CFG_BASE_PLAIN], cfg[127:120]);
    chk("cce after power-up", mem[CFG_BASE_PLAIN + CFG_OPT_INDEX][0], cal_en);
    chk("touch enable after power-up", 1'b1, touch_en);
    $display("test power_up done");
    chk("answers left over", 0, expq.size());
    final_report();
  end
endmodule
